// >>> include/ocm_pkg.sv
package ocm_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int CH_NUM     = 8;
  localparam int PAR_NUM    = 4;
  localparam int MODE_W     = 2;
  localparam int FRAME_BITS = 16;
  localparam int FCNT_W     = 5;

  localparam logic [FCNT_W-1:0] FRAME_CNT = FCNT_W'(FRAME_BITS);
  localparam logic [FCNT_W-1:0] FCNT_SAT  = '1;

  // ---------------------------------------------------------------
  // channel mode codes and reset values
  // ---------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_OFF  = 2'h3;
  localparam logic [MODE_W-1:0] MODE_ON   = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PAR  = 2'h1;
  localparam logic [MODE_W-1:0] MODE_STBY = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RST  = MODE_OFF;
  localparam logic              TER_RST   = 1'b1;

  // status field positions inside each channel's 2-bit slot
  localparam int STAT_OVL_BIT = 0;
  localparam int STAT_OT_BIT  = 1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS         = 40;
  localparam int OVL_FILTER_US  = 3;
  localparam int OVL_FILTER_CYC = (OVL_FILTER_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int OVL_CNT_W      = 7;

  localparam logic [OVL_CNT_W-1:0] OVL_LAST = OVL_CNT_W'(OVL_FILTER_CYC - 1);

  localparam int SCLK_PERIOD_NS = 320;
  localparam int CSB_HIGH_NS    = 1500;
  localparam int TCNT_W         = 8;

  localparam logic [TCNT_W-1:0] SCLK_HALF_CYC = TCNT_W'(SCLK_PERIOD_NS / (2 * CLK_NS));
  localparam logic [TCNT_W-1:0] CS_LEAD_CYC   = TCNT_W'(2 * (SCLK_PERIOD_NS / (2 * CLK_NS)));
  localparam logic [TCNT_W-1:0] CSB_HIGH_CYC  = TCNT_W'((CSB_HIGH_NS + CLK_NS - 1) / CLK_NS);

  // ---------------------------------------------------------------
  // host register map (apb, byte offsets)
  // ---------------------------------------------------------------
  localparam int APB_AW = 8;

  localparam logic [APB_AW-1:0] REG_CTRL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] REG_TX_OFS   = 8'h04;
  localparam logic [APB_AW-1:0] REG_RX_OFS   = 8'h08;

  localparam int CTRL_W        = 2 + PAR_NUM;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_LIMP_BIT = 1;
  localparam int CTRL_PAR_LSB  = 2;
  localparam int RX_BUSY_BIT   = 16;

  localparam logic [CTRL_W-1:0] CTRL_RST = '0;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_UVLO, ST_LOWIQ, ST_NORMAL, ST_LIMP} ocm_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TRAIL, H_GAP} ocm_host_state_t;

endpackage

// >>> include/ocm_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface ocm_link_if;
  logic                        sclk;
  logic                        chip_select_low_n;
  logic                        mosi;
  logic                        miso;
  logic                        miso_oe;
  logic                        miso_line;
  logic                        enable;
  logic                        limp_home_input;
  logic [ocm_pkg::PAR_NUM-1:0] par_in;

  // released serial output reads low
  assign miso_line = miso_oe ? miso : 1'b0;

  modport dev (
    input  sclk, chip_select_low_n, mosi, enable, limp_home_input, par_in,
    output miso, miso_oe
  );

  modport host (
    output sclk, chip_select_low_n, mosi, enable, limp_home_input, par_in,
    input  miso_line
  );
endinterface

`default_nettype wire

// >>> core/ocm_dev.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - 2-bit code per channel: off/on/input/standby
// - standby: output off, diagnostic sink off
// - input mode follows its parallel input pin
// - all standby gives global standby state
// - reset: modes off, status clear, error set
// - needs both supplies; limp ignores logic supply
// - power-up off without sink; otherwise sink on
// - enable rising edge restores all defaults; in limp home the state holds and nothing is restored
// - serial control only when enabled and powered
// - overload past 3 us latches channel off
// - faults clear on standby command or reset
// - faults checked continuously while channel on
// - separate thermal latch per channel
// - supply low: all off; exit by pins
// - limp: channels 1-4 follow inputs, 5-8 off
// - enable and limp low: lowest current, off
// - pin pulses beyond 50 us always seen
// - input n drives channels n and n+4
// - limp ignores commands, still reports faults
// - leaving limp resets registers, sink off
// - 16-bit msb-first frames, 2 bits per channel
module ocm_dev (
  input  wire logic                       ref_clk_i,
  input  wire logic                       nrst_i,
  ocm_link_if.dev                         link,
  input  wire logic                       analog_supply_ok_i,
  input  wire logic                       logic_supply_ok_i,
  input  wire logic [ocm_pkg::CH_NUM-1:0] overload_sense_i,
  input  wire logic [ocm_pkg::CH_NUM-1:0] overtemp_sense_i,
  output logic      [ocm_pkg::CH_NUM-1:0] channel_output_o,
  output logic      [ocm_pkg::CH_NUM-1:0] diag_sink_en_o,
  output logic                            global_standby_o,
  output logic                            lowest_current_state_o,
  output logic                            limp_mode_o,
  output logic                            transmission_error_flag_o
);
  import ocm_pkg::*;

  localparam int SYNC_W = 7 + PAR_NUM + 2 * CH_NUM;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0]     sync_raw;
  logic [SYNC_W-1:0]     sync1_q;
  logic [SYNC_W-1:0]     sync2_q;
  logic                  sclk_s;
  logic                  csn_s;
  logic                  mosi_s;
  logic                  en_s;
  logic                  lhi_s;
  logic                  ana_s;
  logic                  log_s;
  logic [PAR_NUM-1:0]    par_s;
  logic [CH_NUM-1:0]     ovl_s;
  logic [CH_NUM-1:0]     ot_s;

  assign sync_raw = {link.sclk, link.chip_select_low_n, link.mosi, link.enable,
                     link.limp_home_input, analog_supply_ok_i, logic_supply_ok_i,
                     link.par_in, overload_sense_i, overtemp_sense_i};

  // every pin crosses two flops; a pulse of one clock or more survives
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
    end
  end

  assign {sclk_s, csn_s, mosi_s, en_s, lhi_s, ana_s, log_s, par_s, ovl_s, ot_s} = sync2_q;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ocm_dev_state_t        state_q;
  ocm_dev_state_t        state_d;
  logic                  sclk_prev_q;
  logic                  csn_prev_q;
  logic                  sclk_rise;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  init;
  logic                  active;
  logic                  frame_end;
  logic                  frame_ok;
  logic                  apply;
  logic [FRAME_BITS-1:0] sr_q;
  logic [FCNT_W-1:0]     cnt_q;
  logic [FRAME_BITS-1:0] status_w;
  logic [MODE_W-1:0]     mode_q [CH_NUM];
  logic                  diag_en_q;
  logic [CH_NUM-1:0]     ovl_q;
  logic [CH_NUM-1:0]     ot_q;
  logic [OVL_CNT_W-1:0]  ovl_cnt_q [CH_NUM];
  logic [CH_NUM-1:0]     clr_ch;
  logic [CH_NUM-1:0]     drive_d;
  logic [CH_NUM-1:0]     sink_d;
  logic                  all_stby;
  logic                  miso_oe_q;

  function automatic logic [MODE_W-1:0] f_mode_of(input logic [FRAME_BITS-1:0] w, input int ch);
    f_mode_of = w[ch*MODE_W +: MODE_W];
  endfunction

  // ---------------------------------------------------------------
  // operating state
  // ---------------------------------------------------------------
  // limp home keeps running on the analog supply alone
  always_comb begin
    if (!ana_s || (!log_s && !lhi_s)) begin
      state_d = ST_UVLO;
    end else if (lhi_s) begin
      state_d = ST_LIMP;
    end else if (en_s) begin
      state_d = ST_NORMAL;
    end else begin
      state_d = ST_LOWIQ;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_UVLO;
    end else begin
      state_q <= state_d;
    end
  end

  // any change of state, and every idle state, restores defaults;
  // an enable rising edge passes through a state change unless limp home or supply low holds the state
  assign init   = (state_d != state_q) || (state_d == ST_UVLO) || (state_d == ST_LOWIQ);
  assign active = (state_q == ST_NORMAL) || (state_q == ST_LIMP);

  // ---------------------------------------------------------------
  // serial frame
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev_q <= 1'b0;
      csn_prev_q  <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      csn_prev_q  <= csn_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign cs_fall   = csn_prev_q && !csn_s;
  assign cs_rise   = !csn_prev_q && csn_s;

  // status slots: one per channel, channel 1 in the low bits
  always_comb begin
    status_w = '0;
    for (int ch = 0; ch < CH_NUM; ch++) begin
      status_w[ch*MODE_W + STAT_OVL_BIT] = ovl_q[ch];
      status_w[ch*MODE_W + STAT_OT_BIT]  = ot_q[ch];
    end
  end

  // status is loaded at select and shifted out msb first while the
  // command shifts in behind it, so the word also chains onward
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_q  <= '0;
      cnt_q <= '0;
    end else if (init || !active) begin
      cnt_q <= '0;
    end else if (cs_fall) begin
      sr_q  <= status_w;
      cnt_q <= '0;
    end else if (!csn_s && sclk_rise) begin
      sr_q <= {sr_q[FRAME_BITS-2:0], mosi_s};
      if (cnt_q != FCNT_SAT) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign frame_end = active && !init && cs_rise;
  assign frame_ok  = frame_end && (cnt_q == FRAME_CNT);
  assign apply     = frame_ok && (state_q == ST_NORMAL);

  // a frame of any other length is flagged and discarded
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      transmission_error_flag_o <= TER_RST;
    end else if (init) begin
      transmission_error_flag_o <= TER_RST;
    end else if (frame_end) begin
      transmission_error_flag_o <= !frame_ok;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= active && !csn_s;
    end
  end

  assign link.miso    = sr_q[FRAME_BITS-1];
  assign link.miso_oe = miso_oe_q;

  // ---------------------------------------------------------------
  // channel modes and diagnostic enable
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        mode_q[ch] <= MODE_RST;
      end
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        if (init) begin
          mode_q[ch] <= MODE_RST;
        end else if (apply) begin
          mode_q[ch] <= f_mode_of(sr_q, ch);
        end
      end
    end
  end

  // sink stays off after power-up until the first accepted command
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      diag_en_q <= 1'b0;
    end else if (init) begin
      diag_en_q <= 1'b0;
    end else if (apply) begin
      diag_en_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // fault latches
  // ---------------------------------------------------------------
  always_comb begin
    for (int ch = 0; ch < CH_NUM; ch++) begin
      clr_ch[ch] = apply && (f_mode_of(sr_q, ch) == MODE_STBY);
    end
  end

  // overload must persist through the filter before it trips; a set in
  // the same cycle as a standby clear wins
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovl_q <= '0;
      for (int ch = 0; ch < CH_NUM; ch++) begin
        ovl_cnt_q[ch] <= '0;
      end
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        if (init) begin
          ovl_q[ch]     <= 1'b0;
          ovl_cnt_q[ch] <= '0;
        end else if (channel_output_o[ch] && ovl_s[ch]) begin
          ovl_cnt_q[ch] <= (ovl_cnt_q[ch] == OVL_LAST) ? ovl_cnt_q[ch] : ovl_cnt_q[ch] + 1'b1;
          if (ovl_cnt_q[ch] == OVL_LAST) begin
            ovl_q[ch] <= 1'b1;
          end else if (clr_ch[ch]) begin
            ovl_q[ch] <= 1'b0;
          end
        end else begin
          ovl_cnt_q[ch] <= '0;
          if (clr_ch[ch]) begin
            ovl_q[ch] <= 1'b0;
          end
        end
      end
    end
  end

  // each channel has its own thermal latch
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ot_q <= '0;
    end else if (init) begin
      ot_q <= '0;
    end else begin
      ot_q <= ot_s | (ot_q & ~clr_ch);
    end
  end

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  always_comb begin
    all_stby = 1'b1;
    for (int ch = 0; ch < CH_NUM; ch++) begin
      drive_d[ch] = 1'b0;
      sink_d[ch]  = 1'b0;
      if (mode_q[ch] != MODE_STBY) begin
        all_stby = 1'b0;
      end
      if (state_q == ST_NORMAL) begin
        unique case (mode_q[ch])
          MODE_ON:   drive_d[ch] = 1'b1;
          MODE_PAR:  drive_d[ch] = par_s[ch % PAR_NUM];
          MODE_OFF:  sink_d[ch]  = diag_en_q;
          MODE_STBY: drive_d[ch] = 1'b0;
        endcase
      end else if (state_q == ST_LIMP) begin
        drive_d[ch] = (ch < PAR_NUM) ? par_s[ch % PAR_NUM] : 1'b0;
      end
      drive_d[ch] = drive_d[ch] && !ovl_q[ch] && !ot_q[ch];
    end
  end

  // registered so every output is a clean flop; one cycle of latency
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      channel_output_o       <= '0;
      diag_sink_en_o         <= '0;
      global_standby_o       <= 1'b0;
      lowest_current_state_o <= 1'b0;
      limp_mode_o            <= 1'b0;
    end else begin
      channel_output_o       <= drive_d;
      diag_sink_en_o         <= sink_d;
      global_standby_o       <= (state_q == ST_NORMAL) && all_stby;
      lowest_current_state_o <= (state_q == ST_LOWIQ);
      limp_mode_o            <= (state_q == ST_LIMP);
    end
  end

endmodule

`default_nettype wire

// >>> core/ocm_host.sv
`timescale 1ns/100ps
`default_nettype none

module ocm_host (
  input  wire logic                       ref_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [ocm_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  ocm_link_if.host                        link
);
  import ocm_pkg::*;

  ocm_host_state_t       st_q;
  logic [CTRL_W-1:0]     ctrl_q;
  logic [FRAME_BITS-1:0] sh_q;
  logic [FRAME_BITS-1:0] rx_q;
  logic [TCNT_W-1:0]     tcnt_q;
  logic [FCNT_W-1:0]     bit_q;
  logic                  sclk_q;
  logic                  csn_q;
  logic                  mosi_q;
  logic                  miso1_q;
  logic                  miso_s;
  logic                  acc_first;
  logic                  acc_done;
  logic                  start;

  // ---------------------------------------------------------------
  // apb slave: one wait state, write lands at the completing edge
  // ---------------------------------------------------------------
  assign acc_first = psel_i && penable_i && !pready_o;
  assign acc_done  = psel_i && penable_i && pready_o;
  assign start     = acc_done && pwrite_i && (paddr_i == REG_TX_OFS) && (st_q == H_IDLE);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc_first;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
      if (acc_first) begin
        unique case (paddr_i)
          REG_CTRL_OFS: prdata_o[CTRL_W-1:0] <= ctrl_q;
          REG_TX_OFS:   prdata_o[FRAME_BITS-1:0] <= sh_q;
          REG_RX_OFS:   prdata_o <= {15'h0000, st_q != H_IDLE, rx_q};
          default:      pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // pin levels for enable, limp home and parallel inputs
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (acc_done && pwrite_i && (paddr_i == REG_CTRL_OFS)) begin
      ctrl_q <= pwdata_i[CTRL_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // serial master
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso1_q <= 1'b0;
      miso_s  <= 1'b0;
    end else begin
      miso1_q <= link.miso_line;
      miso_s  <= miso1_q;
    end
  end

  // lead time covers the far end's input synchroniser before bit 15
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q   <= H_IDLE;
      sh_q   <= '0;
      rx_q   <= '0;
      tcnt_q <= '0;
      bit_q  <= '0;
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      mosi_q <= 1'b0;
    end else if (st_q == H_IDLE) begin
      if (start) begin
        sh_q   <= pwdata_i[FRAME_BITS-1:0];
        mosi_q <= pwdata_i[FRAME_BITS-1];
        csn_q  <= 1'b0;
        bit_q  <= '0;
        tcnt_q <= CS_LEAD_CYC - 1'b1;
        st_q   <= H_LEAD;
      end
    end else if (tcnt_q != '0) begin
      tcnt_q <= tcnt_q - 1'b1;
    end else begin
      unique case (st_q)
        H_LEAD, H_LOW: begin
          sclk_q <= 1'b1;
          rx_q   <= {rx_q[FRAME_BITS-2:0], miso_s};
          tcnt_q <= SCLK_HALF_CYC - 1'b1;
          st_q   <= H_HIGH;
        end
        H_HIGH: begin
          sclk_q <= 1'b0;
          bit_q  <= bit_q + 1'b1;
          sh_q   <= {sh_q[FRAME_BITS-2:0], 1'b0};
          mosi_q <= sh_q[FRAME_BITS-2];
          tcnt_q <= SCLK_HALF_CYC - 1'b1;
          st_q   <= (bit_q == FRAME_CNT - 1'b1) ? H_TRAIL : H_LOW;
        end
        H_TRAIL: begin
          csn_q  <= 1'b1;
          tcnt_q <= CSB_HIGH_CYC - 1'b1;
          st_q   <= H_GAP;
        end
        H_GAP:   st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.sclk              = sclk_q;
  assign link.chip_select_low_n = csn_q;
  assign link.mosi              = mosi_q;
  assign link.enable            = ctrl_q[CTRL_EN_BIT];
  assign link.limp_home_input   = ctrl_q[CTRL_LIMP_BIT];
  assign link.par_in            = ctrl_q[CTRL_PAR_LSB +: PAR_NUM];

endmodule

`default_nettype wire

// >>> verification/ocm_link_checker.sv
`timescale 1ns/100ps
`default_nettype none

module ocm_link_checker (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sclk,
  input wire logic chip_select_low_n,
  input wire logic mosi,
  input wire logic miso_oe
);
  logic       sclk_q;
  logic [4:0] rise_q;
  logic [7:0] gap_q;

  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  // rising serial clock edges inside the current frame
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_q <= 1'b0;
      rise_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      rise_q <= chip_select_low_n ? 5'h00 : rise_q + 5'(sclk & ~sclk_q);
    end
  end

  // deselect time; starts saturated so the first frame after reset is not flagged
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_q <= 8'hff;
    end else begin
      gap_q <= !chip_select_low_n ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_sclk_idle;
    chip_select_low_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock active while deselected");
  property p_lead;
    $fell(chip_select_low_n) |-> !sclk [*8] ##1 sclk;
  endproperty
  a_lead: assert property (p_lead) else $error("select lead time wrong");
  property p_high;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_high: assert property (p_high) else $error("serial clock high time wrong");
  property p_low;
    $fell(sclk) |-> !sclk [*4];
  endproperty
  a_low: assert property (p_low) else $error("serial clock low time short");
  property p_mosi;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi: assert property (p_mosi) else $error("data moved while clock high");
  property p_count;
    $rose(chip_select_low_n) |-> rise_q == 5'h10;
  endproperty
  a_count: assert property (p_count) else $error("frame is not sixteen bits");
  property p_gap;
    $fell(chip_select_low_n) |-> gap_q >= 8'h26;
  endproperty
  a_gap: assert property (p_gap) else $error("deselect time too short");
  property p_oe_off;
    $rose(chip_select_low_n) |-> ##8 !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("serial output not released");
  property p_oe_on;
    $rose(miso_oe) |-> !chip_select_low_n && !$past(chip_select_low_n, 3);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("serial output enabled out of frame");
endmodule

`default_nettype wire

// >>> verification/octal_channel_mode_control_tb.sv
`timescale 1ns/100ps
`default_nettype none

module octal_channel_mode_control_tb;
  import ocm_pkg::*;

  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ana_ok    = 1'b1;
  logic        log_ok    = 1'b1;
  logic [7:0]  ovl       = 8'h00;
  logic [7:0]  otp       = 8'h00;
  logic [7:0]  out_w;
  logic [7:0]  sink_w;
  logic        gstby_w;
  logic        lowiq_w;
  logic        limp_w;
  logic        err_w;
  logic [31:0] rd;
  logic        serr;
  int          num_errors = 0;
  int          n_checks   = 0;

  // 40 ns reference clock
  always #20 ref_clk_i = ~ref_clk_i;

  ocm_link_if i_link ();
  ocm_host i_ocm_host (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(i_link.host));
  ocm_dev i_ocm_dev (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(i_link.dev), .analog_supply_ok_i(ana_ok),
    .logic_supply_ok_i(log_ok), .overload_sense_i(ovl), .overtemp_sense_i(otp), .channel_output_o(out_w),
    .diag_sink_en_o(sink_w), .global_standby_o(gstby_w), .lowest_current_state_o(lowiq_w),
    .limp_mode_o(limp_w), .transmission_error_flag_o(err_w));
  ocm_link_checker i_ocm_link_checker (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk(i_link.sclk),
    .chip_select_low_n(i_link.chip_select_low_n), .mosi(i_link.mosi), .miso_oe(i_link.miso_oe));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; an edge passes first so psel is never set twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      wrap_up();
    end
  endtask

  // control word, then time for the pin synchronisers and state change
  task automatic ctl(input logic [31:0] v);
    apb(1'b1, REG_CTRL_OFS, v);
    repeat (8) @(posedge ref_clk_i);
  endtask

  // poll busy until the frame and its deselect gap are over
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_RX_OFS, 32'h0000_0000);
      n++;
    end while (rd[RX_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic send(input logic [15:0] c);
    apb(1'b1, REG_TX_OFS, {16'h0000, c});
    idle();
  endtask

  task automatic pins(input logic [7:0] eo, input logic [7:0] es);
    chk("outputs", {24'h00_0000, out_w}, {24'h00_0000, eo});
    chk("sinks", {24'h00_0000, sink_w}, {24'h00_0000, es});
  endtask

  task automatic st(input logic [3:0] e);
    chk("state", {28'h000_0000, gstby_w, lowiq_w, limp_w, err_w}, {28'h000_0000, e});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    wt(5);
    nrst_i <= 1'b1;
    wt(8);
    pins(8'h00, 8'h00);
    st(4'b0101);
    ctl(32'h0000_0001);
    pins(8'h00, 8'h00);
    st(4'b0001);
    apb(1'b0, REG_CTRL_OFS, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped", {serr, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, REG_TX_OFS, 32'h0000_AAAA);
    pins(8'h00, 8'h00);
    idle();
    pins(8'hFF, 8'h00);
    st(4'b0000);
    // standby, input, on and off side by side
    ctl(32'h0000_0009);
    send(16'hC9E4);
    pins(8'h26, 8'h88);
    ctl(32'h0000_0005);
    pins(8'h34, 8'h88);
    // overload shorter than the filter must not trip
    ovl <= 8'h04;
    wt(70);
    pins(8'h34, 8'h88);
    ovl <= 8'h00;
    wt(4);
    ovl <= 8'h04;
    wt(80);
    ovl <= 8'h00;
    otp <= 8'h20;
    wt(4);
    otp <= 8'h00;
    wt(4);
    pins(8'h10, 8'h88);
    send(16'hC9E4);
    chk("status", {16'h0000, rd[15:0]}, 32'h0000_0810);
    send(16'hC9C4);
    send(16'hC9E4);
    pins(8'h14, 8'h88);
    chk("status", {16'h0000, rd[15:0]}, 32'h0000_0800);
    send(16'h0000);
    pins(8'h00, 8'h00);
    st(4'b1000);
    // limp home with the parallel inputs 1 and 3 high
    ctl(32'h0000_0016);
    pins(8'h05, 8'h00);
    st(4'b0011);
    send(16'hAAAA);
    pins(8'h05, 8'h00);
    log_ok <= 1'b0;
    wt(8);
    pins(8'h05, 8'h00);
    ana_ok <= 1'b0;
    wt(8);
    pins(8'h00, 8'h00);
    ana_ok <= 1'b1;
    log_ok <= 1'b1;
    wt(8);
    ovl <= 8'h01;
    wt(80);
    ovl <= 8'h00;
    wt(4);
    pins(8'h04, 8'h00);
    ctl(32'h0000_0015);
    pins(8'h00, 8'h00);
    st(4'b0001);
    ctl(32'h0000_0000);
    st(4'b0101);
    wrap_up();
  end
endmodule

`default_nettype wire
